// file: common/ipsd_pkg.sv
// constants for the load parameter and configuration switch decoder
package ipsd_pkg;
  // register bus
  localparam int          ADDR_W            = 4;
  localparam logic [3:0]  OFF_PARAM_WORD    = 4'h0; // load_parameter_switch_word
  localparam logic [3:0]  OFF_LOAD_STATUS   = 4'h1; // decoded load controls
  localparam logic [3:0]  OFF_SEC_ADDR      = 4'h2; // physical_address_pair
  localparam logic [3:0]  OFF_SEC_OPFIELD   = 4'h3; // operation field
  localparam logic [3:0]  OFF_PRIORITY      = 4'h4; // request_priority_value
  localparam logic [3:0]  OFF_REQ_PENDING   = 4'h5; // pending request mask (rw)
  localparam logic [3:0]  OFF_GRANT         = 4'h6; // granted unit
  localparam logic [3:0]  OFF_REL_ENABLE    = 4'h7; // release request gate
  localparam logic [3:0]  OFF_REL_SOURCE    = 4'h8; // adapters raising (rw)
  // parameter word reset / factory value
  localparam logic [15:0] PARAM_RESET       = 16'h4380;
  // field positions, bit 0 is the lsb of the halfword
  localparam int          POS_AUTO_RESTART  = 14;
  localparam int          POS_EXT_TEST      = 13;
  localparam int          POS_INIT_STORE    = 12;
  localparam int          POS_DEV_TYPE_LO   = 8;
  localparam int          POS_SEC_ADDR_LO   = 4;
  localparam int          POS_DEV_ADDR_LO   = 0;
  // device type codes
  localparam logic [3:0]  DEV_DISKETTE      = 4'h1;
  localparam logic [3:0]  DEV_DISK          = 4'h3;
  localparam logic [3:0]  DEV_MAINT         = 4'hF;
  // abandon display code
  localparam logic [15:0] ABANDON_CODE      = 16'h0122;
  // fixed physical address digits
  localparam logic [3:0]  SEC_ADDR_LOW      = 4'h8;
  localparam logic [7:0]  PRI_PHYS_ADDR     = 8'h08;
  // secondary units arbitrated
  localparam int          NUM_UNITS         = 8;
  localparam int          UNIT_W            = 3;
  // load source decode
  typedef enum logic [1:0] {
    IPSD_SRC_NONE     = 2'b00,
    IPSD_SRC_DISKETTE = 2'b01,
    IPSD_SRC_DISK     = 2'b10,
    IPSD_SRC_MAINT    = 2'b11
  } ipsd_src_e;
endpackage

// file: common/ipsd_arb_if.sv
// request and priority lines between the decoder and its arbiter
`timescale 1ns/1ns
`default_nettype none
interface ipsd_arb_if;
  logic [ipsd_pkg::NUM_UNITS-1:0]   req;
  logic [ipsd_pkg::NUM_UNITS*4-1:0] prio;
  logic                             grant_vld;
  logic [ipsd_pkg::UNIT_W-1:0]      grant_id;
  modport req_side (output req, output prio, input grant_vld, input grant_id);
  modport arb_side (input req, input prio, output grant_vld, output grant_id);
endinterface
`default_nettype wire

// file: rtl/ipsd_prio_arb.sv
// priority arbiter among secondary units
`timescale 1ns/1ns
`default_nettype none
module ipsd_prio_arb (
  // clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // arbitration lines
  ipsd_arb_if.arb_side arb
);
  logic [ipsd_pkg::UNIT_W-1:0] best_id;
  logic [3:0]                  best_val;
  logic                        any;

  // RL11 highest nibble wins
  always_comb begin
    best_id  = '0;
    best_val = 4'h0;
    any      = 1'b0;
    for (int i = 0; i < ipsd_pkg::NUM_UNITS; i++) begin
      if (arb.req[i] && (!any || arb.prio[i*4 +: 4] > best_val)) begin
        any      = 1'b1;
        best_val = arb.prio[i*4 +: 4];
        best_id  = ipsd_pkg::UNIT_W'(i);
      end
    end
  end

  // registered grant
  always_ff @(posedge clk) begin
    if (srst) begin
      arb.grant_vld <= 1'b0;
      arb.grant_id  <= '0;
    end else begin
      arb.grant_vld <= any;
      arb.grant_id  <= best_id;
    end
  end
endmodule
`default_nettype wire

// file: rtl/ipsd_rel_gate.sv
// per-adapter release request gating
`timescale 1ns/1ns
`default_nettype none
module ipsd_rel_gate (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // gate and sources
  input  wire logic [7:0] enable,
  input  wire logic [7:0] source,
  // gated result
  output logic      [7:0] rel_req
);
  genvar g;
  // RL9 one switch per line
  generate
    for (g = 0; g < 8; g++) begin : g_line
      always_ff @(posedge clk) begin
        if (srst) begin
          rel_req[g] <= 1'b0;
        end else begin
          rel_req[g] <= enable[g] & source[g];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// file: rtl/ipsd_top.sv
// load parameter and configuration switch decoder, top level
// ---------------------------------------------------------------
// Summary of operation
// RL1: bit 1 set runs primary load; clear abandons and shows 0122.
// RL2: bit 2 extended test, bit 3 storage init, bit 0 reserved.
// RL3: bits 4-7 give source type: 0001 diskette, 0011 disk, 1111 maint.
// RL4: bits 8-11 secondary unit address, bits 12-15 device within it.
// RL5: every switch inverted before the register; factory reads 4380. Only load_sw is inverted; module switches are used as they stand.
// RL6: secondary address high digit from module 1 switches 1-4, low 8.
// RL7: requester sends primary address then secondary address.
// RL8: op field bits from switches 6,7,8,9,10,5; two low bits zero.
// RL9: module 2 switches each gate one adapter release request.
// RL10: module 1 switches 7-10 form the request priority nibble.
// RL11: pending unit with largest priority nibble is granted.
// RL12: parameter word read whole as a halfword, bit 0 the msb.
// ---------------------------------------------------------------
//
// Our own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
module ipsd_top (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // raw switch contacts, high when closed
  input  wire logic [15:0] load_sw,   // index 0 is parameter bit 0
  input  wire logic [9:0]  mod1_sw,   // index 0 is switch 1
  input  wire logic [7:0]  mod2_sw,   // index 0 is switch 1
  // register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // decoded load controls
  output logic             load_start,
  output logic             load_abandon,
  output logic      [15:0] panel_code,
  output logic             ext_test,
  output logic             init_storage,
  output logic      [1:0]  load_source,
  output logic      [3:0]  load_unit_addr,
  output logic      [3:0]  load_dev_addr,
  // secondary unit configuration
  output logic      [15:0] phys_addr_pair,
  output logic      [7:0]  op_field,
  output logic      [3:0]  req_priority,
  output logic      [7:0]  release_req,
  output logic             grant_valid,
  output logic      [2:0]  grant_unit
);
  // ---------------------------------------------------------------
  // parameter word capture
  // ---------------------------------------------------------------
  logic [15:0] param_r;
  logic [15:0] param_nxt;
  logic [7:0]  rel_src_r;
  logic [7:0]  pend_r;
  logic [3:0]  prio_nib;
  logic [7:0]  rel_gated;

  // RL5 invert switches, RL12 bit 0 to msb
  always_comb begin
    param_nxt = '0;
    for (int i = 0; i < 16; i++) begin
      param_nxt[15-i] = ~load_sw[i];
    end
  end

  // sample the inverted word each cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      param_r <= ipsd_pkg::PARAM_RESET;
    end else begin
      param_r <= param_nxt;
    end
  end

  // ---------------------------------------------------------------
  // load field decode
  // ---------------------------------------------------------------
  // RL1 auto restart or abandon
  always_ff @(posedge clk) begin
    if (srst) begin
      load_start   <= 1'b0;
      load_abandon <= 1'b0;
      panel_code   <= '0;
    end else begin
      load_start   <= param_r[ipsd_pkg::POS_AUTO_RESTART];
      load_abandon <= ~param_r[ipsd_pkg::POS_AUTO_RESTART];
      panel_code   <= param_r[ipsd_pkg::POS_AUTO_RESTART] ?
                      16'h0000 : ipsd_pkg::ABANDON_CODE;
    end
  end

  // RL2 test and storage options
  always_ff @(posedge clk) begin
    if (srst) begin
      ext_test     <= 1'b0;
      init_storage <= 1'b0;
    end else begin
      ext_test     <= param_r[ipsd_pkg::POS_EXT_TEST];
      init_storage <= param_r[ipsd_pkg::POS_INIT_STORE];
    end
  end

  // RL3 source type decode
  always_ff @(posedge clk) begin
    if (srst) begin
      load_source <= ipsd_pkg::IPSD_SRC_NONE;
    end else begin
      case (param_r[ipsd_pkg::POS_DEV_TYPE_LO +: 4])
        ipsd_pkg::DEV_DISKETTE: load_source <= ipsd_pkg::IPSD_SRC_DISKETTE;
        ipsd_pkg::DEV_DISK:     load_source <= ipsd_pkg::IPSD_SRC_DISK;
        ipsd_pkg::DEV_MAINT:    load_source <= ipsd_pkg::IPSD_SRC_MAINT;
        default:                load_source <= ipsd_pkg::IPSD_SRC_NONE;
      endcase
    end
  end

  // RL4 device address split
  always_ff @(posedge clk) begin
    if (srst) begin
      load_unit_addr <= '0;
      load_dev_addr  <= '0;
    end else begin
      load_unit_addr <= param_r[ipsd_pkg::POS_SEC_ADDR_LO +: 4];
      load_dev_addr  <= param_r[ipsd_pkg::POS_DEV_ADDR_LO +: 4];
    end
  end

  // ---------------------------------------------------------------
  // secondary unit configuration
  // ---------------------------------------------------------------
  // RL10 switches 7-10, switch 7 msb
  assign prio_nib = {mod1_sw[6], mod1_sw[7], mod1_sw[8], mod1_sw[9]};

  // RL6 RL7 primary address then secondary address
  always_ff @(posedge clk) begin
    if (srst) begin
      phys_addr_pair <= '0;
    end else begin
      phys_addr_pair <= {ipsd_pkg::PRI_PHYS_ADDR,
                         mod1_sw[0], mod1_sw[1], mod1_sw[2], mod1_sw[3],
                         ipsd_pkg::SEC_ADDR_LOW};
    end
  end

  // RL8 op field from switches 6,7,8,9,10,5
  always_ff @(posedge clk) begin
    if (srst) begin
      op_field <= '0;
    end else begin
      op_field <= {mod1_sw[5], mod1_sw[6], mod1_sw[7], mod1_sw[8],
                   mod1_sw[9], mod1_sw[4], 2'b00};
    end
  end

  // RL10 priority output
  always_ff @(posedge clk) begin
    if (srst) begin
      req_priority <= '0;
    end else begin
      req_priority <= prio_nib;
    end
  end

  // ---------------------------------------------------------------
  // software-written request state
  // ---------------------------------------------------------------
  // pending mask and release sources
  always_ff @(posedge clk) begin
    if (srst) begin
      pend_r    <= '0;
      rel_src_r <= '0;
    end else if (reg_wr) begin
      if (reg_addr == ipsd_pkg::OFF_REQ_PENDING) begin
        pend_r <= reg_wdata[7:0];
      end
      if (reg_addr == ipsd_pkg::OFF_REL_SOURCE) begin
        rel_src_r <= reg_wdata[7:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // arbitration and release gating
  // ---------------------------------------------------------------
  ipsd_arb_if arb_bus ();

  // unit 0 is this unit; others take their own index as nibble below
  assign arb_bus.req = pend_r;

  // each unit's nibble: this unit's switches, others as index value
  genvar u;
  generate
    for (u = 0; u < ipsd_pkg::NUM_UNITS; u++) begin : g_prio
      if (u == 0) begin : g_own
        assign arb_bus.prio[3:0] = prio_nib;
      end else begin : g_other
        assign arb_bus.prio[u*4 +: 4] = 4'(u);
      end
    end
  endgenerate

  // RL11 arbiter
  ipsd_prio_arb u_arb (
    .clk  (clk),
    .srst (srst),
    .arb  (arb_bus.arb_side)
  );

  // RL9 release gate
  ipsd_rel_gate u_rel (
    .clk     (clk),
    .srst    (srst),
    .enable  (mod2_sw),
    .source  (rel_src_r),
    .rel_req (rel_gated)
  );

  // registered copies for the ports
  always_ff @(posedge clk) begin
    if (srst) begin
      release_req <= '0;
      grant_valid <= 1'b0;
      grant_unit  <= '0;
    end else begin
      release_req <= rel_gated;
      grant_valid <= arb_bus.grant_vld;
      grant_unit  <= arb_bus.grant_id;
    end
  end

  // ---------------------------------------------------------------
  // register read
  // ---------------------------------------------------------------
  // register index map, one halfword each:
  //   0 load parameter word, inverted switches, read only
  //   1 decoded load controls {abandon, start, ext test, init}
  //   2 physical address pair, primary byte high
  //   3 secondary unit operation field in the low byte
  //   4 request priority nibble of this unit
  //   5 pending request mask, written by software
  //   6 grant result {valid, unit}
  //   7 module 2 release enables as seen on the switches
  //   8 adapters raising a release request, written by software
  // writes to read-only or unmapped indexes are dropped silently.
  //
  // read data stands for exactly the cycle after the strobe and is
  // zero otherwise, so a host that samples late sees zero, not a
  // stale value; this keeps the port free of any hold logic.
  //
  // the parameter word is resampled every cycle; a switch moved
  // between two reads simply shows up in the second one. decoded
  // outputs lag the word register by one further edge.
  logic [15:0] rd_nxt;

  // RL12 halfword read mux, unmapped reads zero
  always_comb begin
    rd_nxt = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        ipsd_pkg::OFF_PARAM_WORD:  rd_nxt = param_r;
        ipsd_pkg::OFF_LOAD_STATUS: rd_nxt = {12'h000, load_abandon,
                                      load_start, ext_test, init_storage};
        ipsd_pkg::OFF_SEC_ADDR:    rd_nxt = phys_addr_pair;
        ipsd_pkg::OFF_SEC_OPFIELD: rd_nxt = {8'h00, op_field};
        ipsd_pkg::OFF_PRIORITY:    rd_nxt = {12'h000, req_priority};
        ipsd_pkg::OFF_REQ_PENDING: rd_nxt = {8'h00, pend_r};
        ipsd_pkg::OFF_GRANT:       rd_nxt = {12'h000, grant_valid,
                                             grant_unit};
        ipsd_pkg::OFF_REL_ENABLE:  rd_nxt = {8'h00, mod2_sw};
        ipsd_pkg::OFF_REL_SOURCE:  rd_nxt = {8'h00, rel_src_r};
        default:                   rd_nxt = 16'h0000;
      endcase
    end
  end

  // read data register, one cycle after the strobe
  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= rd_nxt;
    end
  end
endmodule
`default_nettype wire

// file: verification/ipsd_monitor.sv
// assertion checker for the switch decoder top level
`timescale 1ns/1ns
`default_nettype none
module ipsd_monitor (
  // clock and reset
  input wire logic        clk,
  input wire logic        srst,
  // switch and bus inputs
  input wire logic [15:0] load_sw,
  input wire logic [9:0]  mod1_sw,
  input wire logic [7:0]  mod2_sw,
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  // watched outputs
  input wire logic [15:0] reg_rdata,
  input wire logic        load_start,
  input wire logic        load_abandon,
  input wire logic [15:0] panel_code,
  input wire logic [15:0] phys_addr_pair,
  input wire logic [7:0]  op_field,
  input wire logic [3:0]  req_priority,
  input wire logic [7:0]  release_req,
  input wire logic        grant_valid,
  input wire logic [2:0]  grant_unit
);
  // ------------------------------------------
  // helpers
  // ------------------------------------------
  logic [9:0] m1_r; // module 1 switches one edge back
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // delay switches to line up with registered outputs
  always_ff @(posedge clk) begin
    m1_r <= mod1_sw;
  end
  // inverted, bit 0 to the msb
  function automatic logic [15:0] flip(input logic [15:0] s);
    for (int i = 0; i < 16; i++) begin
      flip[15-i] = ~s[i];
    end
  endfunction
  sequence s_quiet;
    (!reg_wr) [*4];
  endsequence
  sequence s_pend(logic [7:0] v);
    reg_wr && reg_addr == ipsd_pkg::OFF_REQ_PENDING && reg_wdata[7:0] == v;
  endsequence
  // ------------------------------------------
  // properties
  // ------------------------------------------
  // whole inverted word
  property p_rd_word;
    reg_rd && reg_addr == 4'h0 && !$past(srst) && $stable(load_sw)
      |=> reg_rdata == flip($past(load_sw));
  endproperty
  a_rd_word: assert property (p_rd_word)
    else $error("parameter word read mismatch");
  property p_panel;
    panel_code == (load_abandon ? 16'h0122 : 16'h0000);
  endproperty
  a_panel: assert property (p_panel)
    else $error("panel code mismatch");
  property p_load_go;
    (!srst && $stable(load_sw[1])) [*3]
      |-> load_start == !load_sw[1] && load_abandon == load_sw[1];
  endproperty
  a_load_go: assert property (p_load_go)
    else $error("load start or abandon wrong");
  property p_phys;
    !$past(srst) |-> phys_addr_pair ==
      {8'h08, m1_r[0], m1_r[1], m1_r[2], m1_r[3], 4'h8};
  endproperty
  a_phys: assert property (p_phys)
    else $error("physical address pair wrong");
  property p_op;
    !$past(srst) |-> op_field ==
      {m1_r[5], m1_r[6], m1_r[7], m1_r[8], m1_r[9], m1_r[4], 2'b00};
  endproperty
  a_op: assert property (p_op)
    else $error("op field wrong");
  property p_prio;
    !$past(srst) |-> req_priority == {m1_r[6], m1_r[7], m1_r[8], m1_r[9]};
  endproperty
  a_prio: assert property (p_prio)
    else $error("priority nibble wrong");
  property p_release;
    $stable(mod2_sw) [*4] |-> (release_req & ~mod2_sw) == 8'h00;
  endproperty
  a_release: assert property (p_release)
    else $error("release request not gated");
  property p_grant_none;
    s_pend(8'h00) ##1 s_quiet |=> !grant_valid;
  endproperty
  a_grant_none: assert property (p_grant_none)
    else $error("grant with nothing pending");
  property p_grant_solo;
    s_pend(8'h80) ##1 s_quiet |=> grant_valid && grant_unit == 3'h7;
  endproperty
  a_grant_solo: assert property (p_grant_solo)
    else $error("sole request not granted");
endmodule
bind ipsd_top ipsd_monitor u_ipsd_monitor (
  .clk, .srst, .load_sw, .mod1_sw, .mod2_sw, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .load_start, .load_abandon, .panel_code,
  .phys_addr_pair, .op_field, .req_priority, .release_req, .grant_valid,
  .grant_unit
);
`default_nettype wire

// file: verification/ipsd_pio_host.sv
// programmed i/o host model driving the register port
`timescale 1ns/1ns
`default_nettype none
module ipsd_pio_host (
  // clock
  input  wire logic        clk,
  // register port
  output logic      [3:0]  reg_addr,
  output logic      [15:0] reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd,
  input  wire logic [15:0] reg_rdata
);
  // idle bus from time zero
  initial begin
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // one-cycle write, data scrambled once released
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// file: verification/ipsd_top_test.sv
// self-checking bench for the switch decoder
`timescale 1ns/1ns
`default_nettype none
module ipsd_top_test;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [15:0] load_sw = 16'hFE3D; // factory positions
  logic [9:0]  mod1_sw = 10'h000;
  logic [7:0]  mod2_sw = 8'h00;
  logic [3:0]  reg_addr, load_unit_addr, load_dev_addr, req_priority;
  logic [15:0] reg_wdata, reg_rdata, panel_code, phys_addr_pair;
  logic [7:0]  op_field, release_req;
  logic [1:0]  load_source;
  logic [2:0]  grant_unit;
  logic        reg_wr, reg_rd, load_start, load_abandon;
  logic        ext_test, init_storage, grant_valid;
  int          n_mismatch = 0;
  int          n_tests = 0;
  ipsd_top u_ipsd_top (.clk, .srst, .load_sw, .mod1_sw, .mod2_sw, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .load_start, .load_abandon,
    .panel_code, .ext_test, .init_storage, .load_source, .load_unit_addr,
    .load_dev_addr, .phys_addr_pair, .op_field, .req_priority, .release_req,
    .grant_valid, .grant_unit);
  ipsd_pio_host u_ipsd_pio_host (.clk, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata);
  always #4 clk = ~clk;
  // compare and count
  task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic chk_rd(input logic [3:0] a, input logic [15:0] e);
    logic [15:0] d;
    u_ipsd_pio_host.rd(a, d);
    chk("reg_rdata", e, d);
  endtask
  // move switches, let the pipeline settle
  task automatic set_sw(input logic [15:0] l, input logic [9:0] m1,
                        input logic [7:0] m2);
    @(posedge clk);
    load_sw <= l;
    mod1_sw <= m1;
    mod2_sw <= m2;
    repeat (4) @(posedge clk);
    @(negedge clk);
  endtask
  // switch positions for a wanted word
  function automatic logic [15:0] flip(input logic [15:0] s);
    for (int i = 0; i < 16; i++) begin
      flip[15-i] = ~s[i];
    end
  endfunction
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    #20000;
    n_mismatch++;
    wrap_up();
  end
  // ------------------------------------------
  // tests
  // ------------------------------------------
  initial begin
    logic [15:0] pt [4] = '{16'h4380, 16'hB187, 16'h4FC8, 16'h6280};
    logic [49:0] rows [6] = '{
      {10'h093, 8'h80, 1'b1, 3'h7, 16'h08C8, 8'h24, 4'h4},
      {10'h093, 8'h06, 1'b1, 3'h2, 16'h08C8, 8'h24, 4'h4},
      {10'h093, 8'h00, 1'b0, 3'h0, 16'h08C8, 8'h24, 4'h4},
      {10'h2DA, 8'h81, 1'b1, 3'h0, 16'h0858, 8'h6C, 4'hD},
      {10'h380, 8'h81, 1'b1, 3'h0, 16'h0808, 8'h38, 4'h7},
      {10'h380, 8'h86, 1'b1, 3'h7, 16'h0808, 8'h38, 4'h7}};
    logic [15:0] p, ph;
    logic [9:0]  m1;
    logic [7:0]  mk, of;
    logic [3:0]  pr;
    logic [2:0]  gu;
    logic [1:0]  src;
    logic        gv;
    repeat (5) @(posedge clk);
    @(negedge clk);
    chk("load_start", 16'h0000, load_start);
    @(posedge clk);
    srst <= 1'b0;
    chk_rd(4'h0, 16'h4380);
    u_ipsd_pio_host.wr(4'h0, 16'h0000);
    chk_rd(4'h0, 16'h4380);
    chk_rd(4'hF, 16'h0000);
    $display("test reset done");
    foreach (pt[k]) begin
      p = pt[k];
      set_sw(flip(p), mod1_sw, mod2_sw);
      case (p[11:8])
        4'h1: src = 2'h1;
        4'h3: src = 2'h2;
        4'hF: src = 2'h3;
        default: src = 2'h0;
      endcase
      chk("load_start", p[14], load_start);
      chk("load_abandon", !p[14], load_abandon);
      chk("panel_code", p[14] ? 16'h0000 : 16'h0122, panel_code);
      chk("ext_test", p[13], ext_test);
      chk("init_storage", p[12], init_storage);
      chk("load_source", src, load_source);
      chk("load_addr", p[7:0], {load_unit_addr, load_dev_addr});
      chk_rd(4'h0, p);
    end
    $display("test load word done");
    foreach (rows[k]) begin
      {m1, mk, gv, gu, ph, of, pr} = rows[k];
      set_sw(load_sw, m1, mod2_sw);
      chk("phys_addr_pair", ph, phys_addr_pair);
      chk("op_field", of, op_field);
      chk("req_priority", pr, req_priority);
      chk_rd(4'h2, ph);
      u_ipsd_pio_host.wr(4'h5, {8'h00, mk});
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk("grant_valid", gv, grant_valid);
      if (gv) chk("grant_unit", gu, grant_unit);
    end
    $display("test secondary done");
    set_sw(load_sw, mod1_sw, 8'hA5);
    u_ipsd_pio_host.wr(4'h8, 16'h003C);
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("release_req", 8'h24, release_req);
    chk_rd(4'h7, 16'h00A5);
    set_sw(load_sw, mod1_sw, 8'hFF);
    chk("release_req", 8'h3C, release_req);
    $display("test release done");
    wrap_up();
  end
endmodule
`default_nettype wire
